// File: hdl/udc_counter.sv
// Function
// - Hold a four-bit binary count, shown on the count outputs, counting up or down.
// - Load strobe low copies the preset value into the count, overriding everything else.
// - Count enable high with load released keeps the count unchanged.
// - With load released and enable low, the count moves only on count clock rises.
// - Direction low counts up on each enabled edge; direction high counts down.
// - Terminal flag is high at zero counting down or fifteen counting up.
// - Terminal flag stays high until the count or the direction changes.
// - Ripple strobe follows the count clock only while flag high and enable low.
// - Terminal flag depends on count and direction only, never on count enable.
// - Ripple strobe returns high right after the count clock rises.
module udc_counter
  import udc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic load_strobe_n,
  input wire logic count_enable_n,
  input wire logic count_down,
  input wire logic count_clock,
  input wire logic [COUNT_W-1:0] preset_value,
  output logic [COUNT_W-1:0] count_value,
  output logic terminal_flag,
  output logic ripple_strobe_n,
  input wire logic [ADDR_W-1:0] bus_addr,
  input wire logic [DATA_W-1:0] bus_wr_data,
  input wire logic bus_wr_stb,
  input wire logic bus_rd_stb,
  output logic [DATA_W-1:0] bus_rd_data,
  output logic irq
);

  // ----------------------------------------------------------------
  // Pin synchronisation
  // ----------------------------------------------------------------
  // All pins arrive from outside this clock domain. The two-flop delay
  // means the load no longer acts instantly; it lands two cycles later.
  udc_pins_s pins_raw;
  udc_pins_s pins;
  logic [PINS_W-1:0] pins_sync;

  assign pins_raw = '{load_strobe_n, count_enable_n, count_down, count_clock, preset_value};

  udc_sync #(
    .WIDTH(PINS_W),
    .RESET_VALUE(PINS_RESET)
  ) u_pin_sync (
    .ref_clk(ref_clk),
    .reset(reset),
    .clk_en(clk_en),
    .async_in(pins_raw),
    .sync_out(pins_sync)
  );

  assign pins = udc_pins_s'(pins_sync);

  udc_bus_req_s req;

  assign req = '{bus_addr, bus_wr_data, bus_wr_stb, bus_rd_stb};

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [COUNT_W-1:0] count;
    logic flag;
    logic ripple_n;
    logic down;
    logic clk_prev;
    logic halt;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic irq_out;
    logic [DATA_W-1:0] rd_data;
  } udc_state_s;

  udc_state_s s;
  udc_state_s next_s;

  logic clk_rise;
  logic count_on;
  logic loading;
  logic stepping;
  logic [IRQ_W-1:0] events;
  logic [IRQ_W-1:0] clear_bits;

  assign clk_rise = pins.count_clock & ~s.clk_prev;
  assign count_on = ~pins.count_enable_n & ~s.halt;
  assign loading = ~pins.load_strobe_n;
  assign stepping = ~loading & count_on & clk_rise;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    events = '0;
    clear_bits = '0;
    if (clk_en)
    begin
      next_s.clk_prev = pins.count_clock;
      next_s.down = pins.count_down;
      if (loading)
      begin
        next_s.count = pins.preset_value;
      end
      else if (stepping)
      begin
        // Four-bit arithmetic wraps by itself in both directions.
        if (pins.count_down)
        begin
          next_s.count = s.count - 4'h1;
        end
        else
        begin
          next_s.count = s.count + 4'h1;
        end
      end
      // Without a step or a load the count simply holds.

      // The flag is decoded from the new count and direction only, so it
      // stays up until one of those moves and ignores count enable.
      if (pins.count_down)
      begin
        next_s.flag = (next_s.count == COUNT_BOTTOM);
      end
      else
      begin
        next_s.flag = (next_s.count == COUNT_TOP);
      end

      // Low only while the clock is low, so a rising clock releases it.
      next_s.ripple_n = ~(next_s.flag & count_on & ~pins.count_clock);

      events[IRQ_FLAG_BIT] = next_s.flag & ~s.flag;
      events[IRQ_LOAD_BIT] = loading;
      events[IRQ_WRAP_BIT] = stepping & s.flag;

      if (req.wr_stb)
      begin
        unique case (req.addr)
          CTRL_OFFSET:
          begin
            next_s.halt = req.wr_data[CTRL_HALT_BIT];
          end
          IRQ_STATUS_OFFSET:
          begin
            clear_bits = req.wr_data[IRQ_W-1:0];
          end
          IRQ_MASK_OFFSET:
          begin
            next_s.irq_mask = req.wr_data[IRQ_W-1:0];
          end
          default:
          begin
            next_s.halt = s.halt;
          end
        endcase
      end

      // A new event beats a clear landing in the same cycle.
      next_s.irq_status = (s.irq_status & ~clear_bits) | events;
      next_s.irq_out = |(next_s.irq_status & next_s.irq_mask);

      next_s.rd_data = '0;
      if (req.rd_stb)
      begin
        unique case (req.addr)
          CTRL_OFFSET:
          begin
            next_s.rd_data[CTRL_HALT_BIT] = s.halt;
          end
          STATE_OFFSET:
          begin
            next_s.rd_data[STATE_COUNT_LSB +: COUNT_W] = s.count;
            next_s.rd_data[STATE_FLAG_BIT] = s.flag;
            next_s.rd_data[STATE_DOWN_BIT] = s.down;
            next_s.rd_data[STATE_LOAD_BIT] = loading;
          end
          IRQ_STATUS_OFFSET:
          begin
            next_s.rd_data[IRQ_W-1:0] = s.irq_status;
          end
          IRQ_MASK_OFFSET:
          begin
            next_s.rd_data[IRQ_W-1:0] = s.irq_mask;
          end
          default:
          begin
            next_s.rd_data = '0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      s <= '{
        count: COUNT_RESET,
        flag: 1'b0,
        ripple_n: 1'b1,
        down: 1'b0,
        clk_prev: 1'b0,
        halt: CTRL_HALT_RESET,
        irq_status: IRQ_STATUS_RESET,
        irq_mask: IRQ_MASK_RESET,
        irq_out: 1'b0,
        rd_data: '0
      };
    end
    else
    begin
      s <= next_s;
    end
  end

  assign count_value = s.count;
  assign terminal_flag = s.flag;
  assign ripple_strobe_n = s.ripple_n;
  assign bus_rd_data = s.rd_data;
  assign irq = s.irq_out;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking

  default disable iff (reset);

  chk_load_copy: assert property (clk_en && loading |=> count_value == $past(pins.preset_value))
    else $error("Load did not copy the preset value.");

  chk_hold_disabled: assert property (clk_en && !loading && pins.count_enable_n |=> $stable(count_value))
    else $error("Count moved while count enable was high.");

  chk_hold_no_edge: assert property (clk_en && !loading && !clk_rise |=> $stable(count_value))
    else $error("Count moved without a count clock rise.");

  chk_step_up: assert property (clk_en && stepping && !pins.count_down
    |=> count_value == 4'($past(count_value) + 4'h1))
    else $error("Up step did not add one modulo sixteen.");

  chk_step_down: assert property (clk_en && stepping && pins.count_down
    |=> count_value == 4'($past(count_value) - 4'h1))
    else $error("Down step did not subtract one modulo sixteen.");

  chk_flag_decode: assert property (terminal_flag == (s.down ? count_value == COUNT_BOTTOM
    : count_value == COUNT_TOP))
    else $error("Terminal flag disagrees with count and direction.");

  chk_flag_stays: assert property (terminal_flag ##1 ($stable(count_value) && $stable(s.down))
    |-> terminal_flag)
    else $error("Terminal flag fell with count and direction unchanged.");

  chk_ripple_gate: assert property (clk_en |=> ripple_strobe_n
    || (terminal_flag && $past(count_on && !pins.count_clock)))
    else $error("Ripple strobe went low without flag, enable and low clock.");

  chk_ripple_follow: assert property (clk_en && count_on && !pins.count_clock ##1 terminal_flag
    |-> !ripple_strobe_n)
    else $error("Ripple strobe stayed high with flag, enable and low clock.");

  chk_wrap_up: assert property (clk_en && stepping && !pins.count_down && count_value == COUNT_TOP
    |=> count_value == COUNT_BOTTOM)
    else $error("Up count did not wrap from fifteen to zero.");

  chk_ripple_release: assert property (clk_en && pins.count_clock |=> ripple_strobe_n)
    else $error("Ripple strobe stayed low with the count clock high.");

  chk_irq_level: assert property (irq == |$past(next_s.irq_status & next_s.irq_mask))
    else $error("Interrupt output does not match masked status.");

  chk_halt_hold: assert property (clk_en && s.halt && !loading |=> $stable(count_value))
    else $error("Count moved while halted.");

  chk_set_wins: assert property (clk_en && (|events) |=> (s.irq_status & $past(events)) == $past(events))
    else $error("Interrupt event was lost.");

  chk_mask_write: assert property (clk_en && bus_wr_stb && bus_addr == IRQ_MASK_OFFSET
    |=> s.irq_mask == $past(bus_wr_data[IRQ_W-1:0]))
    else $error("Mask write did not land.");

  chk_rd_idle: assert property (clk_en && !bus_rd_stb |=> bus_rd_data == '0)
    else $error("Read data stood outside its cycle.");

  cov_wrap_up: cover property (clk_en && stepping && !pins.count_down && count_value == COUNT_TOP);
  cov_wrap_down: cover property (clk_en && stepping && pins.count_down && count_value == COUNT_BOTTOM);
  cov_load: cover property (clk_en && loading ##1 !loading);
  cov_ripple: cover property (!ripple_strobe_n ##[1:4] ripple_strobe_n);
  cov_irq_rise: cover property (clk_en && !irq ##1 irq);

endmodule

// File: hdl/udc_pkg.sv
package udc_pkg;

  // ----------------------------------------------------------------
  // Counter geometry
  // ----------------------------------------------------------------
  localparam int COUNT_W = 4;
  localparam logic [3:0] COUNT_TOP = 4'hf;
  localparam logic [3:0] COUNT_BOTTOM = 4'h0;
  localparam logic [3:0] COUNT_RESET = 4'h0;
  localparam int SYNC_STAGES = 2;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [3:0] CTRL_OFFSET = 4'h0;
  localparam logic [3:0] STATE_OFFSET = 4'h4;
  localparam logic [3:0] IRQ_STATUS_OFFSET = 4'h8;
  localparam logic [3:0] IRQ_MASK_OFFSET = 4'hc;

  // Control register fields.
  localparam int CTRL_HALT_BIT = 0;
  localparam logic CTRL_HALT_RESET = 1'b0;

  // State register fields.
  localparam int STATE_COUNT_LSB = 0;
  localparam int STATE_FLAG_BIT = 4;
  localparam int STATE_DOWN_BIT = 5;
  localparam int STATE_LOAD_BIT = 6;

  // Interrupt status and mask fields.
  localparam int IRQ_W = 3;
  localparam int IRQ_FLAG_BIT = 0;
  localparam int IRQ_LOAD_BIT = 1;
  localparam int IRQ_WRAP_BIT = 2;
  localparam logic [2:0] IRQ_STATUS_RESET = 3'h0;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic load_strobe_n;
    logic count_enable_n;
    logic count_down;
    logic count_clock;
    logic [3:0] preset_value;
  } udc_pins_s;

  localparam int PINS_W = $bits(udc_pins_s);
  localparam udc_pins_s PINS_RESET = '{1'b1, 1'b1, 1'b0, 1'b0, 4'h0};

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wr_data;
    logic wr_stb;
    logic rd_stb;
  } udc_bus_req_s;

endpackage

// File: hdl/udc_sync.sv
module udc_sync
  import udc_pkg::*;
#(
  parameter int WIDTH = PINS_W,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
)
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // ----------------------------------------------------------------
  // Two-stage synchroniser
  // ----------------------------------------------------------------
  // The first stage feeds only the second one; nothing else may look at it.
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } udc_sync_state_s;

  udc_sync_state_s s;
  udc_sync_state_s next_s;

  always_comb
  begin
    next_s = s;
    if (clk_en)
    begin
      next_s.meta = async_in;
      next_s.stable = s.meta;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      s <= '{RESET_VALUE, RESET_VALUE};
    end
    else
    begin
      s <= next_s;
    end
  end

  assign sync_out = s.stable;

endmodule

// File: tb/udc_partner.sv
module udc_partner
  import udc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire udc_pins_s want,
  output udc_pins_s pins
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [2:0] div;

  // ----------------------------------------------------------------
  // Pin driver
  // ----------------------------------------------------------------
  // The clock field of want only asks the pin clock to run.
  // A stopped clock rests at its last level, so enable and direction may change safely.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      pins <= PINS_RESET;
      div <= 3'h0;
    end
    else
    begin
      div <= div + 3'h1;
      if (want.count_clock && div == 3'h7)
      begin
        pins.count_clock <= ~pins.count_clock;
      end
      pins.load_strobe_n <= want.load_strobe_n;
      pins.preset_value <= want.preset_value;
      if (!want.count_enable_n || pins.count_clock)
      begin
        pins.count_enable_n <= want.count_enable_n;
      end
      if (pins.count_enable_n || pins.count_clock)
      begin
        pins.count_down <= want.count_down;
      end
    end
  end
endmodule

// File: tb/tb_top.sv
module tb_top
  import udc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic ref_clk;
  logic reset;
  logic clk_en;
  udc_pins_s want;
  udc_pins_s w;
  udc_pins_s pins;
  logic [ADDR_W-1:0] bus_addr;
  logic [DATA_W-1:0] bus_wr_data;
  logic [DATA_W-1:0] bus_rd_data;
  logic bus_wr_stb;
  logic bus_rd_stb;
  logic irq;
  logic terminal_flag;
  logic ripple_strobe_n;
  logic [COUNT_W-1:0] count_value;
  int errors;
  int total_checks;
  logic [3:0] upper;
  logic clk_seen;

  udc_partner peer (.ref_clk(ref_clk), .reset(reset), .want(want), .pins(pins));

  udc_counter DUT (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
    .load_strobe_n(pins.load_strobe_n), .count_enable_n(pins.count_enable_n),
    .count_down(pins.count_down), .count_clock(pins.count_clock),
    .preset_value(pins.preset_value), .count_value(count_value),
    .terminal_flag(terminal_flag), .ripple_strobe_n(ripple_strobe_n),
    .bus_addr(bus_addr), .bus_wr_data(bus_wr_data), .bus_wr_stb(bus_wr_stb),
    .bus_rd_stb(bus_rd_stb), .bus_rd_data(bus_rd_data), .irq(irq));

  // An upper cascade stage: its enable is the lower terminal flag with the global enable and the up
  // direction, sampled on ref_clk, so the decoded flag is never used as a clock.
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      upper <= 4'h0;
      clk_seen <= 1'b0;
    end
    else
    begin
      clk_seen <= pins.count_clock;
      if (pins.count_clock && !clk_seen && terminal_flag && !pins.count_enable_n && !pins.count_down)
        upper <= upper + 4'h1;
    end
  end

  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task report_and_stop;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Compares count, flag and ripple strobe in one go.
  task out_chk(input logic [5:0] exp);
    check({26'h0, count_value, terminal_flag, ripple_strobe_n}, {26'h0, exp});
  endtask

  task bus_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_wr_data <= d;
    bus_wr_stb <= 1'b1;
    @(posedge ref_clk);
    bus_wr_stb <= 1'b0;
  endtask

  task bus_rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_rd_stb <= 1'b1;
    @(posedge ref_clk);
    bus_rd_stb <= 1'b0;
    #1;
    check(bus_rd_data, exp);
  endtask

  task drive_want;
    @(posedge ref_clk);
    want <= w;
  endtask

  // Allows two synchroniser stages, the state edge and registered outputs.
  task settle;
    repeat (6) @(posedge ref_clk);
    #1;
  endtask

  // Sees the pin level from before the edge, so it returns on an edge.
  task wait_lvl(input logic lvl);
    for (int i = 0; i < 40; i++)
    begin
      @(posedge ref_clk);
      if (pins.count_clock === lvl)
        return;
    end
    errors++;
    report_and_stop;
  endtask

  task step(input int n);
    @(posedge ref_clk);
    want.count_clock <= 1'b1;
    repeat (n)
    begin
      wait_lvl(1'b0);
      wait_lvl(1'b1);
    end
    want.count_clock <= 1'b0;
    settle;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    errors = 0;
    total_checks = 0;
    reset = 1'b1;
    clk_en = 1'b1;
    w = PINS_RESET;
    want = PINS_RESET;
    bus_addr = 4'h0;
    bus_wr_data = 32'h0;
    bus_wr_stb = 1'b0;
    bus_rd_stb = 1'b0;
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    #1;
    out_chk({4'h0, 1'b0, 1'b1});
    bus_rd(CTRL_OFFSET, 32'h0);
    bus_rd(STATE_OFFSET, 32'h0);
    bus_rd(IRQ_STATUS_OFFSET, 32'h0);
    bus_rd(IRQ_MASK_OFFSET, 32'h0);
    bus_rd(4'h2, 32'h0);
    @(posedge ref_clk);
    clk_en <= 1'b0;
    bus_wr(IRQ_MASK_OFFSET, 32'h7);
    clk_en <= 1'b1;
    bus_rd(IRQ_MASK_OFFSET, 32'h0);
    w.load_strobe_n = 1'b0;
    w.preset_value = 4'he;
    drive_want;
    settle;
    out_chk({4'he, 1'b0, 1'b1});
    bus_rd(STATE_OFFSET, 32'h4e);
    w.load_strobe_n = 1'b1;
    drive_want;
    settle;
    bus_rd(IRQ_STATUS_OFFSET, 32'h2);
    bus_wr(IRQ_STATUS_OFFSET, 32'h2);
    bus_rd(IRQ_STATUS_OFFSET, 32'h0);
    step(2);
    out_chk({4'he, 1'b0, 1'b1});
    w.count_enable_n = 1'b0;
    drive_want;
    step(1);
    out_chk({4'hf, 1'b1, 1'b1});
    bus_rd(IRQ_STATUS_OFFSET, 32'h1);
    w.count_enable_n = 1'b1;
    drive_want;
    settle;
    out_chk({4'hf, 1'b1, 1'b1});
    step(1);
    out_chk({4'hf, 1'b1, 1'b1});
    w.count_enable_n = 1'b0;
    drive_want;
    @(posedge ref_clk);
    want.count_clock <= 1'b1;
    wait_lvl(1'b0);
    repeat (4) @(posedge ref_clk);
    #1;
    out_chk({4'hf, 1'b1, 1'b0});
    wait_lvl(1'b1);
    want.count_clock <= 1'b0;
    settle;
    out_chk({4'h0, 1'b0, 1'b1});
    check({28'h0, upper}, 32'h1);
    bus_rd(IRQ_STATUS_OFFSET, 32'h5);
    bus_wr(IRQ_MASK_OFFSET, 32'h5);
    settle;
    check({31'h0, irq}, 32'h1);
    bus_wr(IRQ_STATUS_OFFSET, 32'h5);
    settle;
    check({31'h0, irq}, 32'h0);
    w.load_strobe_n = 1'b0;
    w.preset_value = 4'hf;
    drive_want;
    settle;
    out_chk({4'hf, 1'b1, 1'b1});
    w.load_strobe_n = 1'b1;
    w.count_down = 1'b1;
    drive_want;
    settle;
    out_chk({4'hf, 1'b0, 1'b1});
    bus_wr(STATE_OFFSET, 32'h0);
    bus_rd(STATE_OFFSET, 32'h2f);
    step(15);
    out_chk({4'h0, 1'b1, 1'b1});
    step(1);
    out_chk({4'hf, 1'b0, 1'b1});
    bus_wr(CTRL_OFFSET, 32'h1);
    step(2);
    out_chk({4'hf, 1'b0, 1'b1});
    bus_rd(CTRL_OFFSET, 32'h1);
    bus_wr(CTRL_OFFSET, 32'h0);
    step(1);
    out_chk({4'he, 1'b0, 1'b1});
    @(posedge ref_clk);
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    #1;
    out_chk({4'h0, 1'b0, 1'b1});
    check({31'h0, irq}, 32'h0);
    settle;
    out_chk({4'h0, 1'b1, 1'b0});
    report_and_stop;
  end
endmodule
